// ---- rtl/sifm_device.sv ----
// drive end: digital io function mapping and cyclic command objects
`timescale 1ns/1ps
`include "sifm_params.svh"
// Overview of operation
// RL1: input with function code 0 is ignored
// RL2: alarm-clear input rising edge clears clearable alarm
// RL3: ccw limit input off forbids ccw rotation
// RL4: cw limit input off forbids cw rotation
// RL5: limit inhibits only when limit enable selects
// RL6: emergency stop input on stops motor
// RL7: code 23 input is homing reference
// RL8: output code 0 off, code 1 on
// RL9: ready output on when power ok, no alarm
// RL10: fault output off while alarm present
// RL11: brake output follows internal brake logic
// RL12: running output on while motor enabled running
// RL13: torque limit output on at torque limit
// RL14: speed limit output on at speed limit, in cst mode only
// RL15: homing complete output on after homing done
// RL16: network brake output follows output object bit0
// RL17: codes 24-28 follow network output object bits
// RL18: mode selection accepts only 6, 8, 9, 10
// RL19: mode latched when enable command arrives
// RL20: csp target position taken every cycle
// RL21: csv target velocity taken every cycle
module sifm_device
  import sifm_pkg::*;
#(
  parameter int NUM_DI = 8,
  parameter int NUM_DO = 6
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  sifm_link_if.device LINK,
  input wire logic [NUM_DI-1:0] DI_PINS,
  input wire logic [NUM_DI*`SIFM_FUNC_W-1:0] DI_FUNC,
  input wire logic [NUM_DO*`SIFM_FUNC_W-1:0] DO_FUNC,
  input wire logic LIMIT_INHIBIT_ENABLE_PARAM,
  input wire logic [`SIFM_STOP_W-1:0] STOP_METHOD_PARAM,
  input wire logic MAIN_POWER_OK,
  input wire logic ALARM_ACTIVE,
  input wire logic ALARM_CLEARABLE,
  input wire logic BRAKE_RELEASE,
  input wire logic MOTOR_RUNNING,
  input wire logic TORQUE_AT_LIMIT,
  input wire logic SPEED_AT_LIMIT,
  input wire logic HOMING_DONE,
  output logic [NUM_DO-1:0] DO_PINS,
  output logic ALARM_CLEAR,
  output logic CCW_INHIBIT,
  output logic CW_INHIBIT,
  output logic EMERGENCY_STOP,
  output logic [`SIFM_STOP_W-1:0] STOP_METHOD,
  output logic HOME_REFERENCE,
  output logic DRIVE_ENABLED,
  output logic [7:0] ACTIVE_MODE,
  output logic [31:0] POSITION_CMD,
  output logic POSITION_CMD_VALID,
  output logic [31:0] VELOCITY_CMD,
  output logic VELOCITY_CMD_VALID
);
  initial begin
    if (NUM_DI < 1 || NUM_DI > 16) $error("NUM_DI out of range");
    if (NUM_DO < 1 || NUM_DO > 16) $error("NUM_DO out of range");
  end

  // whole state of this end
  typedef struct packed {
    logic [NUM_DI-1:0] di_meta; // first synchroniser stage
    logic [NUM_DI-1:0] di_sync; // second synchroniser stage
    logic clr_level; // alarm-clear level of last cycle
    logic alm_clr; // alarm clear pulse
    logic ccw_inh; // ccw rotation inhibited
    logic cw_inh; // cw rotation inhibited
    logic estop; // emergency stop request
    logic [`SIFM_STOP_W-1:0] stop_m; // stop method handed on
    logic home_ref; // homing reference level
    logic [NUM_DO-1:0] dout; // output pins
    logic [15:0] ctl; // drive_control_word
    logic [7:0] mode_sel; // operating_mode_select
    logic [31:0] tgt_pos; // target_position_command
    logic [31:0] tgt_vel; // target_velocity_command
    logic [31:0] net_out; // digital output object
    logic enabled; // enable command in force
    logic [7:0] act_mode; // mode adopted at enable
    logic [31:0] pos_cmd; // position issued this cycle
    logic pos_vld; // position strobe
    logic [31:0] vel_cmd; // velocity issued this cycle
    logic vel_vld; // velocity strobe
    logic [31:0] rdata; // read answer
    logic rd_vld; // read answer strobe
  } sifm_dev_state_t;

  sifm_dev_state_t s_q, s_d;

  // inputs whose code matches one function, read after synchronising
  function automatic logic [NUM_DI-1:0] di_match(
    input logic [NUM_DI*`SIFM_FUNC_W-1:0] codes,
    input logic [`SIFM_FUNC_W-1:0] fn
  );
    logic [NUM_DI-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_DI; i++) begin
      m[i] = (codes[i*`SIFM_FUNC_W +: `SIFM_FUNC_W] == fn);
    end
    return m;
  endfunction

  // level driven by one output function code
  function automatic logic do_level(
    input logic [`SIFM_FUNC_W-1:0] fn,
    input logic [31:0] net
  );
    logic v;
    v = 1'b0;
    case (fn)
      `SIFM_DO_OFF: v = 1'b0; // [RL8]
      `SIFM_DO_ON: v = 1'b1; // [RL8]
      `SIFM_DO_READY: v = MAIN_POWER_OK && !ALARM_ACTIVE; // [RL9]
      `SIFM_DO_FAULT: v = !ALARM_ACTIVE; // active low alarm [RL10]
      `SIFM_DO_BRAKE: v = BRAKE_RELEASE; // on releases the brake [RL11]
      `SIFM_DO_RUN: v = MOTOR_RUNNING && s_q.enabled; // [RL12]
      `SIFM_DO_TRQ_LIM: v = TORQUE_AT_LIMIT; // [RL13]
      `SIFM_DO_SPD_LIM: v = SPEED_AT_LIMIT && (s_q.act_mode == `SIFM_MODE_CST); // [RL14]
      `SIFM_DO_HOME_DONE: v = HOMING_DONE; // [RL15]
      `SIFM_DO_NET_BRAKE: v = net[`SIFM_DOUT_BRAKE_BIT]; // [RL16]
      default: begin
        // codes 24 to 28 map onto consecutive object bits
        if (fn >= `SIFM_DO_NET_IO1 && fn <= `SIFM_DO_NET_IO5) begin
          v = net[5'(fn - `SIFM_DO_NET_IO1) + 5'(`SIFM_DOUT_NETIO_LSB)]; // [RL17]
        end else begin
          v = 1'b0; // unassigned codes stay off
        end
      end
    endcase
    return v;
  endfunction

  logic [NUM_DI-1:0] clr_on; // alarm-clear inputs that are on
  logic [NUM_DI-1:0] ccw_asg; // inputs assigned to ccw limit
  logic [NUM_DI-1:0] cw_asg; // inputs assigned to cw limit
  logic enable_cmd; // enable bit of the incoming control word

  // next state
  always_comb begin
    s_d = s_q;
    s_d.alm_clr = 1'b0;
    s_d.pos_vld = 1'b0;
    s_d.vel_vld = 1'b0;
    s_d.rd_vld = 1'b0;
    enable_cmd = 1'b0;

    // pins are asynchronous, so two stages before any decode
    s_d.di_meta = DI_PINS;
    s_d.di_sync = s_q.di_meta;

    // only matching codes are looked at, code 0 matches nothing here [RL1]
    clr_on = s_q.di_sync & di_match(DI_FUNC, `SIFM_DI_ALM_CLR);
    ccw_asg = di_match(DI_FUNC, `SIFM_DI_CCW_LIM);
    cw_asg = di_match(DI_FUNC, `SIFM_DI_CW_LIM);

    // alarm clear on off-to-on, clearable alarms only [RL2]
    s_d.clr_level = |clr_on;
    s_d.alm_clr = (|clr_on) && !s_q.clr_level && ALARM_ACTIVE && ALARM_CLEARABLE;

    // limit switches are normally closed: off means forbid; an unassigned
    // direction is never inhibited, so a broken mapping fails open [RL3] [RL4]
    s_d.ccw_inh = LIMIT_INHIBIT_ENABLE_PARAM && (|ccw_asg) &&
                  !(|(s_q.di_sync & ccw_asg)); // [RL5]
    s_d.cw_inh = LIMIT_INHIBIT_ENABLE_PARAM && (|cw_asg) &&
                 !(|(s_q.di_sync & cw_asg)); // [RL5]

    // emergency stop, the stop method itself is left to the drive [RL6]
    s_d.estop = |(s_q.di_sync & di_match(DI_FUNC, `SIFM_DI_ESTOP));
    s_d.stop_m = STOP_METHOD_PARAM;

    // homing reference switch level [RL7]
    s_d.home_ref = |(s_q.di_sync & di_match(DI_FUNC, `SIFM_DI_HOME_REF));

    // output mapping
    for (int j = 0; j < NUM_DO; j++) begin
      s_d.dout[j] = do_level(DO_FUNC[j*`SIFM_FUNC_W +: `SIFM_FUNC_W], s_q.net_out);
    end

    // object writes
    if (LINK.wr_en) begin
      case (LINK.addr)
        `SIFM_OFS_CONTROL: begin
          s_d.ctl = LINK.wdata[15:0];
          enable_cmd = LINK.wdata[`SIFM_CTL_ENABLE_BIT];
        end
        `SIFM_OFS_MODE: begin
          // other values leave the selection unchanged [RL18]
          if (sifm_mode_ok(LINK.wdata[7:0])) begin
            s_d.mode_sel = LINK.wdata[7:0];
          end
        end
        `SIFM_OFS_TGT_POS: s_d.tgt_pos = LINK.wdata;
        `SIFM_OFS_TGT_VEL: s_d.tgt_vel = LINK.wdata;
        `SIFM_OFS_DOUT: s_d.net_out = LINK.wdata; // [RL16] [RL17]
        default: ; // unmapped writes are dropped
      endcase
      if (LINK.addr == `SIFM_OFS_CONTROL) begin
        // mode is sampled once at the enable edge and kept [RL19]
        if (enable_cmd && !s_q.enabled) begin
          s_d.act_mode = s_q.mode_sel;
        end
        s_d.enabled = enable_cmd;
      end
    end

    // per-cycle command hand-off, using the value held at the tick
    if (LINK.cycle_tick && s_q.enabled) begin
      if (s_q.act_mode == `SIFM_MODE_CSP) begin
        s_d.pos_cmd = s_q.tgt_pos; // [RL20]
        s_d.pos_vld = 1'b1; // [RL20]
      end
      if (s_q.act_mode == `SIFM_MODE_CSV) begin
        s_d.vel_cmd = s_q.tgt_vel; // [RL21]
        s_d.vel_vld = 1'b1; // [RL21]
      end
    end

    // object reads, answered on the next edge; unmapped reads give zero
    if (LINK.rd_en) begin
      s_d.rd_vld = 1'b1;
      s_d.rdata = '0;
      case (LINK.addr)
        `SIFM_OFS_CONTROL: s_d.rdata = {16'h0000, s_q.ctl};
        `SIFM_OFS_STATUS: begin
          s_d.rdata[`SIFM_ST_READY_BIT] = MAIN_POWER_OK && !ALARM_ACTIVE;
          s_d.rdata[`SIFM_ST_ENABLED_BIT] = s_q.enabled;
          s_d.rdata[`SIFM_ST_FAULT_BIT] = ALARM_ACTIVE;
          s_d.rdata[`SIFM_ST_HOMED_BIT] = HOMING_DONE;
        end
        `SIFM_OFS_MODE: s_d.rdata = {24'h000000, s_q.mode_sel};
        `SIFM_OFS_TGT_POS: s_d.rdata = s_q.tgt_pos;
        `SIFM_OFS_TGT_VEL: s_d.rdata = s_q.tgt_vel;
        `SIFM_OFS_DOUT: s_d.rdata = s_q.net_out;
        default: s_d.rdata = '0;
      endcase
    end
  end

  // state register; mode starts at homing so it is always a legal value
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.mode_sel <= `SIFM_MODE_HOMING;
      s_q.act_mode <= `SIFM_MODE_HOMING;
    end else begin
      s_q <= s_d;
    end
  end

  assign LINK.rdata = s_q.rdata;
  assign LINK.rd_valid = s_q.rd_vld;
  assign DO_PINS = s_q.dout;
  assign ALARM_CLEAR = s_q.alm_clr;
  assign CCW_INHIBIT = s_q.ccw_inh;
  assign CW_INHIBIT = s_q.cw_inh;
  assign EMERGENCY_STOP = s_q.estop;
  assign STOP_METHOD = s_q.stop_m;
  assign HOME_REFERENCE = s_q.home_ref;
  assign DRIVE_ENABLED = s_q.enabled;
  assign ACTIVE_MODE = s_q.act_mode;
  assign POSITION_CMD = s_q.pos_cmd;
  assign POSITION_CMD_VALID = s_q.pos_vld;
  assign VELOCITY_CMD = s_q.vel_cmd;
  assign VELOCITY_CMD_VALID = s_q.vel_vld;
endmodule

// ---- include/sifm_params.svh ----
// constants shared by both ends of the servo io function mapper
`ifndef SIFM_PARAMS_SVH
`define SIFM_PARAMS_SVH

// object offsets seen on the master link
`define SIFM_OFS_CONTROL 16'h6040
`define SIFM_OFS_STATUS 16'h6041
`define SIFM_OFS_MODE 16'h6060
`define SIFM_OFS_TGT_POS 16'h607a
`define SIFM_OFS_TGT_VEL 16'h60ff
`define SIFM_OFS_DOUT 16'h60fe

// link widths
`define SIFM_ADDR_W 16
`define SIFM_DATA_W 32

// input function codes
`define SIFM_DI_NONE 5'h00
`define SIFM_DI_ALM_CLR 5'h02
`define SIFM_DI_CCW_LIM 5'h03
`define SIFM_DI_CW_LIM 5'h04
`define SIFM_DI_ESTOP 5'h0f
`define SIFM_DI_HOME_REF 5'h17
`define SIFM_FUNC_W 5

// output function codes
`define SIFM_DO_OFF 5'h00
`define SIFM_DO_ON 5'h01
`define SIFM_DO_READY 5'h02
`define SIFM_DO_FAULT 5'h03
`define SIFM_DO_BRAKE 5'h08
`define SIFM_DO_RUN 5'h09
`define SIFM_DO_TRQ_LIM 5'h0b
`define SIFM_DO_SPD_LIM 5'h0c
`define SIFM_DO_HOME_DONE 5'h0d
`define SIFM_DO_NET_BRAKE 5'h17
`define SIFM_DO_NET_IO1 5'h18
`define SIFM_DO_NET_IO5 5'h1c

// operating mode values
`define SIFM_MODE_HOMING 8'h06
`define SIFM_MODE_CSP 8'h08
`define SIFM_MODE_CSV 8'h09
`define SIFM_MODE_CST 8'h0a

// bit positions
`define SIFM_CTL_ENABLE_BIT 3
`define SIFM_DOUT_BRAKE_BIT 0
`define SIFM_DOUT_NETIO_LSB 1
`define SIFM_ST_READY_BIT 0
`define SIFM_ST_ENABLED_BIT 2
`define SIFM_ST_FAULT_BIT 3
`define SIFM_ST_HOMED_BIT 12
`define SIFM_STOP_W 2

// default period of the master's process data cycle, in clocks
`define SIFM_CYCLE_CLKS 100

`endif

// ---- include/sifm_pkg.sv ----
// types shared by both ends of the servo io function mapper
package sifm_pkg;
  `include "sifm_params.svh"

  // operating modes the device accepts
  typedef enum logic [7:0] {
    SIFM_HOMING = `SIFM_MODE_HOMING,
    SIFM_CSP = `SIFM_MODE_CSP,
    SIFM_CSV = `SIFM_MODE_CSV,
    SIFM_CST = `SIFM_MODE_CST
  } sifm_mode_t;

  // true for the four mode values the device accepts
  function automatic logic sifm_mode_ok(input logic [7:0] m);
    return (m == `SIFM_MODE_HOMING) || (m == `SIFM_MODE_CSP) ||
           (m == `SIFM_MODE_CSV) || (m == `SIFM_MODE_CST);
  endfunction
endpackage

// ---- include/sifm_link_if.sv ----
// object access link between the network master and the drive
`timescale 1ns/1ps
interface sifm_link_if;
  logic wr_en; // one-cycle write strobe
  logic rd_en; // one-cycle read strobe
  logic [15:0] addr; // object offset
  logic [31:0] wdata; // write data
  logic [31:0] rdata; // read answer
  logic rd_valid; // read answer strobe
  logic cycle_tick; // start of a process data cycle

  modport master (output wr_en, rd_en, addr, wdata, cycle_tick, input rdata, rd_valid);
  modport device (input wr_en, rd_en, addr, wdata, cycle_tick, output rdata, rd_valid);
endinterface

// ---- rtl/sifm_master.sv ----
// network master end: issues object accesses and the cycle tick
`timescale 1ns/1ps
`include "sifm_params.svh"
module sifm_master
  import sifm_pkg::*;
#(
  parameter int CYCLE_CLKS = `SIFM_CYCLE_CLKS
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  sifm_link_if.master LINK,
  input wire logic USER_WR,
  input wire logic USER_RD,
  input wire logic [15:0] USER_ADDR,
  input wire logic [31:0] USER_WDATA,
  output logic USER_REFUSED,
  output logic [31:0] USER_RDATA,
  output logic USER_RD_VALID
);
  initial begin
    if (CYCLE_CLKS < 2 || CYCLE_CLKS > 65535) $error("CYCLE_CLKS out of range");
  end

  // whole state of this end
  typedef struct packed {
    logic wr; // pending write strobe
    logic rd; // pending read strobe
    logic [15:0] addr; // request offset
    logic [31:0] wdata; // request data
    logic mode_set; // a legal mode has been written
    logic refused; // refusal pulse
    logic [15:0] cyc_cnt; // cycle divider
    logic tick; // cycle tick pulse
    logic [31:0] rdata; // captured answer
    logic rd_valid; // answer pulse
  } sifm_mst_state_t;

  sifm_mst_state_t s_q, s_d;
  logic enable_wr; // request would raise the enable command

  // next state
  always_comb begin
    s_d = s_q;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    s_d.refused = 1'b0;
    s_d.tick = 1'b0;
    s_d.rd_valid = LINK.rd_valid;
    if (LINK.rd_valid) begin
      s_d.rdata = LINK.rdata;
    end
    enable_wr = USER_WR && (USER_ADDR == `SIFM_OFS_CONTROL) &&
                USER_WDATA[`SIFM_CTL_ENABLE_BIT];
    // enable is held back until a mode has been chosen [RL19]
    if (enable_wr && !s_q.mode_set) begin
      s_d.refused = 1'b1;
    end else if (USER_WR || USER_RD) begin
      s_d.wr = USER_WR;
      s_d.rd = USER_RD && !USER_WR;
      s_d.addr = USER_ADDR;
      s_d.wdata = USER_WDATA;
      if (USER_WR && USER_ADDR == `SIFM_OFS_MODE && sifm_mode_ok(USER_WDATA[7:0])) begin
        s_d.mode_set = 1'b1; // [RL19]
      end
    end
    // periodic cycle tick paces the target hand-off; outputs are updated every clock [RL16] [RL17] [RL20] [RL21]
    if (s_q.cyc_cnt == 16'(CYCLE_CLKS - 1)) begin
      s_d.cyc_cnt = 16'h0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cyc_cnt = s_q.cyc_cnt + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign LINK.wr_en = s_q.wr;
  assign LINK.rd_en = s_q.rd;
  assign LINK.addr = s_q.addr;
  assign LINK.wdata = s_q.wdata;
  assign LINK.cycle_tick = s_q.tick;
  assign USER_REFUSED = s_q.refused;
  assign USER_RDATA = s_q.rdata;
  assign USER_RD_VALID = s_q.rd_valid;
endmodule

// ---- verification/sifm_link_chk.sv ----
// checker watching the object link between master and drive
`timescale 1ns/1ps
`include "sifm_params.svh"
module sifm_link_chk
  import sifm_pkg::*;
#(
  parameter int CYCLE_CLKS = `SIFM_CYCLE_CLKS
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic rd_valid,
  input wire logic cycle_tick
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic mode_seen_q; // a legal mode has crossed the link
  logic [7:0] mode_q; // last legal mode written, reset value 6
  logic [15:0] rd_addr_q; // offset of the read being answered
  logic tick_seen_q; // first tick after reset has no gap to judge
  logic [15:0] gap_q; // clocks since the last tick
  logic mode_ok; // write carries one of the four accepted modes
  assign mode_ok = wdata inside {32'h6, 32'h8, 32'h9, 32'ha};
  // helper flops: shadow of what the drive must keep
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mode_seen_q <= 1'b0;
      mode_q <= 8'h06;
      rd_addr_q <= 16'h0;
      tick_seen_q <= 1'b0;
      gap_q <= 16'h0;
    end else begin
      if (wr_en && addr == `SIFM_OFS_MODE && mode_ok) begin
        mode_seen_q <= 1'b1;
        mode_q <= wdata[7:0];
      end
      if (rd_en) begin
        rd_addr_q <= addr;
      end
      tick_seen_q <= tick_seen_q | cycle_tick;
      gap_q <= cycle_tick ? 16'h0 : gap_q + 16'h1;
    end
  end
  a_read_answer_next: assert property (rd_en |=> rd_valid)
    else $error("read strobe not answered on the next cycle");
  a_no_stray_answer: assert property (rd_valid |-> $past(rd_en))
    else $error("read answer without a read");
  a_strobes_apart: assert property (!(rd_en && wr_en))
    else $error("read and write strobes together");
  a_tick_period: assert property (cycle_tick && tick_seen_q |-> gap_q == CYCLE_CLKS - 1)
    else $error("cycle tick spacing wrong");
  a_mode_readback: assert property (rd_valid && rd_addr_q == `SIFM_OFS_MODE
    |-> rdata == {24'h0, mode_q})
    else $error("mode read differs from last accepted mode");
  a_enable_after_mode: assert property (wr_en && addr == `SIFM_OFS_CONTROL && wdata[3]
    |-> mode_seen_q)
    else $error("enable sent before any mode");
  a_ctl_upper_zero: assert property (rd_valid && rd_addr_q == `SIFM_OFS_CONTROL
    |-> rdata[31:16] == 16'h0)
    else $error("control read upper half not zero");
  a_unmapped_zero: assert property (rd_valid && !(rd_addr_q inside {16'h6040, 16'h6041,
    16'h6060, 16'h607a, 16'h60ff, 16'h60fe}) |-> rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

// ---- verification/servo_io_function_mapper_bench.sv ----
// self-checking bench: master and drive joined over the link
`timescale 1ns/1ps
`include "sifm_params.svh"
module servo_io_function_mapper_bench;
  import sifm_pkg::*;
  typedef struct packed {logic [4:0] code; logic [7:0] cond; logic exp;} sifm_row_t;
  logic clock, rst_n, user_wr, user_rd, user_refused, user_rd_valid, lim_en;
  logic [15:0] user_addr;
  logic [31:0] user_wdata, user_rdata, pos_cmd, vel_cmd;
  logic [7:0] di_pins, cond, active_mode; // cond: pwr alm clr brk run trq spd home
  logic [39:0] di_func;
  logic [29:0] do_func;
  logic [1:0] stop_m, stop_out;
  logic [5:0] do_pins;
  logic alarm_clear, ccw_inh, cw_inh, estop, home_ref, enabled, pos_v, vel_v;
  int fails = 0;
  int checked = 0;
  // output code, drive conditions and the level every output should show
  sifm_row_t rows [15] = '{{5'h00, 8'hff, 1'b0}, {5'h01, 8'h00, 1'b1}, {5'h02, 8'h80, 1'b1},
    {5'h02, 8'hc0, 1'b0}, {5'h02, 8'h00, 1'b0}, {5'h03, 8'h40, 1'b0}, {5'h03, 8'h00, 1'b1},
    {5'h08, 8'h10, 1'b1}, {5'h08, 8'hef, 1'b0}, {5'h0b, 8'h04, 1'b1}, {5'h0b, 8'hfb, 1'b0},
    {5'h0d, 8'h01, 1'b1}, {5'h0d, 8'hfe, 1'b0}, {5'h0c, 8'h02, 1'b0}, {5'h09, 8'h08, 1'b0}};
  sifm_link_if link();
  sifm_master #(.CYCLE_CLKS(4)) i_sifm_master (.CLOCK(clock), .RST_N(rst_n), .LINK(link),
    .USER_WR(user_wr), .USER_RD(user_rd), .USER_ADDR(user_addr), .USER_WDATA(user_wdata),
    .USER_REFUSED(user_refused), .USER_RDATA(user_rdata), .USER_RD_VALID(user_rd_valid));
  sifm_device #(.NUM_DI(8), .NUM_DO(6)) i_sifm_device (.CLOCK(clock), .RST_N(rst_n),
    .LINK(link), .DI_PINS(di_pins), .DI_FUNC(di_func), .DO_FUNC(do_func),
    .LIMIT_INHIBIT_ENABLE_PARAM(lim_en), .STOP_METHOD_PARAM(stop_m),
    .MAIN_POWER_OK(cond[7]), .ALARM_ACTIVE(cond[6]), .ALARM_CLEARABLE(cond[5]),
    .BRAKE_RELEASE(cond[4]), .MOTOR_RUNNING(cond[3]), .TORQUE_AT_LIMIT(cond[2]),
    .SPEED_AT_LIMIT(cond[1]), .HOMING_DONE(cond[0]), .DO_PINS(do_pins),
    .ALARM_CLEAR(alarm_clear), .CCW_INHIBIT(ccw_inh), .CW_INHIBIT(cw_inh),
    .EMERGENCY_STOP(estop), .STOP_METHOD(stop_out), .HOME_REFERENCE(home_ref),
    .DRIVE_ENABLED(enabled), .ACTIVE_MODE(active_mode), .POSITION_CMD(pos_cmd),
    .POSITION_CMD_VALID(pos_v), .VELOCITY_CMD(vel_cmd), .VELOCITY_CMD_VALID(vel_v));
  sifm_link_chk #(.CYCLE_CLKS(4)) i_sifm_link_chk (.CLOCK(clock), .RST_N(rst_n),
    .wr_en(link.wr_en), .rd_en(link.rd_en), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .rd_valid(link.rd_valid), .cycle_tick(link.cycle_tick));
  // 10 MHz clock
  always #50 clock = ~clock;
  // compare and count; four-state equality so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // single exit point of the run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask
  // write through the master; second wait lets the drive take the strobe
  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic refused);
    user_wr = 1'b1;
    user_addr = a;
    user_wdata = d;
    @(negedge clock);
    user_wr = 1'b0;
    refused = user_refused;
    @(negedge clock);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    int n;
    user_rd = 1'b1;
    user_addr = a;
    @(negedge clock);
    user_rd = 1'b0;
    for (n = 0; n < 8 && user_rd_valid !== 1'b1; n++) @(negedge clock);
    if (n == 8) begin
      fails++;
      report_and_stop();
    end
    d = user_rdata;
  endtask
  // bounded wait for the cyclic command strobe of position or velocity
  task automatic wait_cmd(input bit pos);
    int n;
    // a tick at the edge that took the write still hands on the old value
    @(negedge clock);
    for (n = 0; n < 12 && (pos ? pos_v : vel_v) !== 1'b1; n++) @(negedge clock);
    if (n == 12) begin
      fails++;
      report_and_stop();
    end
  endtask
  // pins pass two sync stages and a register before showing
  task automatic di_chk(input logic [7:0] pins, input logic [3:0] exp);
    di_pins = pins;
    settle(4);
    check({ccw_inh, cw_inh, estop, home_ref}, exp);
  endtask
  task automatic clr_count(input logic [7:0] pins, output int c);
    di_pins = pins;
    c = 0;
    repeat (6) begin
      @(negedge clock);
      c += alarm_clear;
    end
  endtask
  initial begin
    logic r;
    logic [31:0] d;
    int i, c;
    clock = 1'b0;
    rst_n = 1'b0;
    {user_wr, user_rd, user_addr, user_wdata, di_pins, cond, lim_en} = '0;
    di_func = {5'h00, 5'h00, 5'h00, 5'h17, 5'h0f, 5'h04, 5'h03, 5'h02};
    do_func = '0;
    stop_m = 2'h2;
    settle(8);
    check({active_mode, 2'h0, do_pins}, 16'h0600);
    rst_n = 1'b1;
    settle(2);
    for (i = 0; i < 15; i++) begin
      do_func = {6{rows[i].code}};
      cond = rows[i].cond;
      settle(1);
      check(do_pins, {6{rows[i].exp}});
    end
    cond = 8'h00;
    wr(`SIFM_OFS_CONTROL, 32'h8, r);
    check(r, 1'b1);
    wr(`SIFM_OFS_MODE, 32'h7, r);
    wr(`SIFM_OFS_CONTROL, 32'h8, r);
    check({r, enabled}, 2'h2);
    rd(`SIFM_OFS_MODE, d);
    check(d, 32'h6);
    rd(16'h6071, d);
    check(d, 32'h0);
    wr(`SIFM_OFS_MODE, 32'h9, r);
    wr(`SIFM_OFS_CONTROL, 32'h8, r);
    check({r, enabled, active_mode}, 10'h109);
    wr(`SIFM_OFS_MODE, 32'h8, r);
    check(active_mode, 8'h09);
    wr(`SIFM_OFS_TGT_VEL, 32'h1234abcd, r);
    wait_cmd(1'b0);
    check(vel_cmd, 32'h1234abcd);
    do_func = {6{5'h09}};
    cond = 8'h08;
    settle(1);
    check(do_pins, 6'h3f);
    wr(`SIFM_OFS_CONTROL, 32'h0, r);
    wr(`SIFM_OFS_CONTROL, 32'h8, r);
    check(active_mode, 8'h08);
    wr(`SIFM_OFS_TGT_POS, 32'hfffe0001, r);
    wait_cmd(1'b1);
    check(pos_cmd, 32'hfffe0001);
    wr(`SIFM_OFS_CONTROL, 32'h0, r);
    wr(`SIFM_OFS_MODE, 32'ha, r);
    wr(`SIFM_OFS_CONTROL, 32'h8, r);
    do_func = {6{5'h0c}};
    cond = 8'h02;
    settle(1);
    check({active_mode, 2'h0, do_pins}, 16'h0a3f);
    do_func = {5'h1c, 5'h1b, 5'h1a, 5'h19, 5'h18, 5'h17};
    for (i = 0; i < 2; i++) begin
      d = i ? 32'h2a : 32'h15;
      wr(`SIFM_OFS_DOUT, d, r);
      settle(1);
      check(do_pins, d[5:0]);
    end
    di_chk(8'h00, 4'h0);
    lim_en = 1'b1;
    di_chk(8'h00, 4'hc);
    di_chk(8'h02, 4'h4);
    di_chk(8'h04, 4'h8);
    di_chk(8'h26, 4'h0);
    di_chk(8'h0e, 4'h2);
    check(stop_out, 2'h2);
    di_chk(8'h16, 4'h1);
    cond = 8'h60;
    clr_count(8'h17, c);
    check(c, 1);
    di_chk(8'h16, 4'h1);
    cond = 8'h40;
    clr_count(8'h17, c);
    check(c, 0);
    rd(`SIFM_OFS_STATUS, d);
    check(d, 32'hc);
    rst_n = 1'b0;
    settle(2);
    check({enabled, active_mode}, 9'h006);
    rst_n = 1'b1;
    settle(2);
    report_and_stop();
  end
endmodule
